// >>> common/sadc_pkg.sv
// shared constants, types and helpers for the converter sequencer
// assumes a single 25 MHz cpu clock and an external analog sar core
package sadc_pkg;

   // widths of the control fields
   localparam int unsigned RES_W = 10;
   localparam int unsigned CH_W = 4;
   localparam int unsigned REF_W = 2;
   localparam int unsigned PS_W = 3;
   localparam int unsigned TS_W = 3;
   localparam int unsigned PS_CNT_W = 7;
   localparam int unsigned HALF_W = 6;

   // cpu clock period in ns, for reference
   localparam int unsigned MCLK_PERIOD_NS = 40;

   // conversion timing in converter half cycles (one step per clock edge)
   localparam logic [5:0] NORM_SH_HALF = 6'h03;   // 1.5 cycles
   localparam logic [5:0] NORM_LEN_HALF = 6'h1a;  // 13 cycles
   localparam logic [5:0] FIRST_SH_HALF = 6'h1b;  // 13.5 cycles
   localparam logic [5:0] FIRST_LEN_HALF = 6'h32; // 25 cycles
   localparam logic [5:0] AUTO_SH_HALF = 6'h04;   // 2 cycles
   localparam logic [5:0] AUTO_LEN_HALF = 6'h1b;  // 13.5 cycles

   // cpu cycles from trigger level to prescaler reset
   localparam int unsigned TRIG_SYNC_CYC = 3;

   // trigger source code that selects the own completion flag
   localparam logic [2:0] TS_FREE_RUN = 3'h0;

   // reference and channel codes seen by the analog side
   localparam logic [1:0] REF_EXT_PIN = 2'h0;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [3:0] CH_BANDGAP = 4'he;
   localparam logic [3:0] CH_GROUND = 4'hf;

   // values after reset
   localparam logic [PS_CNT_W-1:0] PS_CNT_RST = 7'h00;
   localparam logic [HALF_W-1:0] HALF_RST = 6'h00;
   localparam logic [7:0] RESULT_BYTE_RST = 8'h00;

   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CONV} sadc_state_e;
   typedef enum logic [1:0] {K_NORMAL, K_FIRST, K_AUTO} sadc_kind_e;

   // control presented to the analog core
   typedef struct packed {
      logic powered;
      logic sample_hold;
      logic [CH_W-1:0] channel;
      logic [REF_W-1:0] reference;
   } sadc_core_ctrl_s;

   // the two result bytes as software sees them
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } sadc_result_s;

   // place a raw 10-bit code right or left justified
   function automatic sadc_result_s sadc_format(input logic [RES_W-1:0] code,
                                                input logic left);
      sadc_result_s r;
      r = left ? {code, 6'h00} : {6'h00, code};
      return r;
   endfunction

endpackage

// >>> verilog/sadc_prescaler.sv
// converter clock prescaler: one-cycle strobes at the rising and falling
// edges of the divided converter clock; assumes synchronous reset copy
`timescale 1ns/1ns
module sadc_prescaler (
   input wire logic mclk_i,                // cpu clock
   input wire logic rst_n_i,               // synchronised reset, active low
   input wire logic run_i,                 // converter enabled
   input wire logic clear_i,               // restart the divider
   input wire logic [2:0] sel_i,           // division select
   output logic rise_o,                    // converter clock rising edge
   output logic fall_o                     // converter clock falling edge
);

   logic [sadc_pkg::PS_CNT_W-1:0] cnt_q;
   logic [sadc_pkg::PS_CNT_W-1:0] last;
   logic [sadc_pkg::PS_CNT_W-1:0] half;

   // terminal counts: codes 0 and 1 both divide by two
   always_comb begin
      last = (sel_i == 3'h0) ? 7'h01 : 7'((8'h01 << sel_i) - 8'h01);
      half = last >> 1;
   end

   // divider counter, held at zero while disabled; wraps at once if the ratio shrinks
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= sadc_pkg::PS_CNT_RST;
      end else if (!run_i || clear_i) begin
         cnt_q <= sadc_pkg::PS_CNT_RST;
      end else if (cnt_q >= last) begin
         cnt_q <= sadc_pkg::PS_CNT_RST;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

   // edge strobes
   assign rise_o = run_i && !clear_i && (cnt_q == last);
   assign fall_o = run_i && !clear_i && (cnt_q == half);

endmodule // sadc_prescaler

// >>> verilog/sadc_sequencer.sv
// converter sequencer: start, triggering, timing, result bytes and flag
// assumes software strobes are one-cycle pulses synchronous to mclk_i
`timescale 1ns/1ns
module sadc_sequencer (
   input wire logic mclk_i,                     // cpu clock, 25 MHz
   input wire logic arst_n_i,                   // async reset, active low
   input wire logic conv_enable_i,              // converter enable level
   input wire logic converter_power_off_i,      // power reduction level
   input wire logic auto_trigger_enable_i,      // auto trigger level
   input wire logic [2:0] trigger_source_sel_i, // trigger select
   input wire logic [2:0] prescale_sel_i,       // prescaler select
   input wire logic [3:0] channel_sel_i,        // channel select
   input wire logic [1:0] reference_sel_i,      // reference select
   input wire logic left_adjust_i,              // left justify result
   input wire logic irq_enable_i,               // completion irq enable
   input wire logic conv_start_wr_i,            // write one to start bit
   input wire logic flag_clear_i,               // write one to done flag
   input wire logic irq_ack_i,                  // completion irq serviced
   input wire logic read_low_i,                 // low byte read strobe
   input wire logic read_high_i,                // high byte read strobe
   input wire logic [7:1] trig_src_i,           // trigger source levels
   input wire logic [9:0] core_result_i,        // code from analog core
   output sadc_pkg::sadc_core_ctrl_s core_ctrl_o, // control to analog core
   output logic [7:0] result_high_o,            // high result byte
   output logic [7:0] result_low_o,             // low result byte
   output logic conv_start_o,                   // start bit readback
   output logic conv_done_flag_o,               // completion flag
   output logic irq_o                           // completion interrupt
);

   logic rst_s1_q;
   logic rst_n;
   logic powered;
   logic adc_rise;
   logic adc_fall;
   logic adc_tick;
   sadc_pkg::sadc_state_e state_q;
   sadc_pkg::sadc_state_e state_d;
   sadc_pkg::sadc_kind_e kind_q;
   sadc_pkg::sadc_kind_e kind_d;
   logic [5:0] half_q;
   logic [5:0] half_d;
   logic [5:0] half_next;
   logic first_q;
   logic free_run;
   logic done_now;
   logic sh_now;
   logic trig_lvl;
   logic trig_s1_q;
   logic trig_s2_q;
   logic trig_s3_q;
   logic trig_edge;
   logic trig_fire;
   logic lock_q;
   logic flag_q;
   logic flag_d;
   logic [3:0] ch_buf_q;
   logic [1:0] ref_buf_q;
   logic track;
   sadc_pkg::sadc_result_s res_q;

   // length of a conversion in half cycles
   function automatic logic [5:0] conv_len(input sadc_pkg::sadc_kind_e k);
      unique case (k)
         sadc_pkg::K_FIRST: conv_len = sadc_pkg::FIRST_LEN_HALF;
         sadc_pkg::K_AUTO: conv_len = sadc_pkg::AUTO_LEN_HALF;
         default: conv_len = sadc_pkg::NORM_LEN_HALF;
      endcase
   endfunction
   // moment of sample-and-hold in half cycles
   function automatic logic [5:0] conv_sh(input sadc_pkg::sadc_kind_e k);
      unique case (k)
         sadc_pkg::K_FIRST: conv_sh = sadc_pkg::FIRST_SH_HALF;
         sadc_pkg::K_AUTO: conv_sh = sadc_pkg::AUTO_SH_HALF;
         default: conv_sh = sadc_pkg::NORM_SH_HALF;
      endcase
   endfunction

   // reset release through two flops
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   assign powered = conv_enable_i && !converter_power_off_i;
   sadc_prescaler u_prescaler (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .run_i(powered),
      .clear_i(trig_fire),
      .sel_i(prescale_sel_i),
      .rise_o(adc_rise),
      .fall_o(adc_fall)
   );
   assign adc_tick = adc_rise || adc_fall;
   assign free_run = auto_trigger_enable_i && (trigger_source_sel_i == sadc_pkg::TS_FREE_RUN);
   assign trig_lvl = (trigger_source_sel_i == sadc_pkg::TS_FREE_RUN) ? 1'b0
                     : trig_src_i[trigger_source_sel_i];
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end else begin
         trig_s1_q <= trig_lvl;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end
   assign trig_edge = trig_s2_q && !trig_s3_q;
   assign trig_fire = auto_trigger_enable_i && powered && trig_edge && (state_q != sadc_pkg::S_CONV);

   // conversion progress at this tick
   assign half_next = half_q + 6'h01;
   assign done_now = (state_q == sadc_pkg::S_CONV) && adc_tick && (half_next == conv_len(kind_q));
   assign sh_now = (state_q == sadc_pkg::S_CONV) && adc_tick && (half_next == conv_sh(kind_q));

   // next state of the sequencer
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      half_d = half_q;
      if (!powered) begin
         state_d = sadc_pkg::S_IDLE;
         half_d = sadc_pkg::HALF_RST;
      end else begin
         unique case (state_q)
            sadc_pkg::S_IDLE: begin
               if (trig_fire) begin
                  state_d = sadc_pkg::S_CONV;
                  kind_d = first_q ? sadc_pkg::K_FIRST : sadc_pkg::K_AUTO;
                  half_d = sadc_pkg::HALF_RST;
               end else if (conv_start_wr_i) begin
                  state_d = sadc_pkg::S_WAIT;
               end
            end
            sadc_pkg::S_WAIT: begin
               if (trig_fire) begin
                  state_d = sadc_pkg::S_CONV;
                  kind_d = first_q ? sadc_pkg::K_FIRST : sadc_pkg::K_AUTO;
                  half_d = sadc_pkg::HALF_RST;
               end else if (adc_rise) begin
                  state_d = sadc_pkg::S_CONV;
                  kind_d = first_q ? sadc_pkg::K_FIRST : sadc_pkg::K_NORMAL;
                  half_d = sadc_pkg::HALF_RST;
               end
            end
            sadc_pkg::S_CONV: begin
               if (done_now) begin
                  half_d = sadc_pkg::HALF_RST;
                  kind_d = sadc_pkg::K_NORMAL;
                  state_d = free_run ? sadc_pkg::S_CONV : sadc_pkg::S_IDLE;
               end else if (adc_tick) begin
                  half_d = half_next;
               end
            end
            default: begin
               state_d = sadc_pkg::S_IDLE;
            end
         endcase
      end
   end

   // sequencer state
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sadc_pkg::S_IDLE;
         kind_q <= sadc_pkg::K_NORMAL;
         half_q <= sadc_pkg::HALF_RST;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         half_q <= half_d;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         first_q <= 1'b1;
      end else if (!powered) begin
         first_q <= 1'b1;
      end else if (done_now) begin
         first_q <= 1'b0;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= (state_d != sadc_pkg::S_IDLE);
      end
   end
   assign track = (state_q != sadc_pkg::S_CONV) || (half_q >= conv_len(kind_q) - 6'h02);
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ch_buf_q <= 4'h0;
         ref_buf_q <= sadc_pkg::REF_EXT_PIN;
      end else if (track && !trig_fire && !(state_q == sadc_pkg::S_WAIT && adc_rise)) begin
         ch_buf_q <= channel_sel_i;
         ref_buf_q <= reference_sel_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         core_ctrl_o <= '0;
      end else begin
         core_ctrl_o.powered <= powered;
         core_ctrl_o.sample_hold <= sh_now;
         core_ctrl_o.channel <= powered ? ch_buf_q : 4'h0;
         core_ctrl_o.reference <= powered ? ref_buf_q : sadc_pkg::REF_EXT_PIN;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= 1'b0;
      end else if (read_low_i) begin
         lock_q <= 1'b1;
      end else if (read_high_i) begin
         lock_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         res_q <= {sadc_pkg::RESULT_BYTE_RST, sadc_pkg::RESULT_BYTE_RST};
      end else if (done_now && !lock_q) begin
         res_q <= sadc_pkg::sadc_format(core_result_i, left_adjust_i);
      end
   end
   assign result_high_o = res_q.high;
   assign result_low_o = res_q.low;

   always_comb begin
      flag_d = flag_q;
      if (flag_clear_i || irq_ack_i) begin
         flag_d = 1'b0;
      end
      if (done_now) begin
         flag_d = 1'b1;
      end
   end

   // completion flag and interrupt
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irq_o <= flag_d && irq_enable_i;
      end
   end
   assign conv_done_flag_o = flag_q;

   // helper: converter rising edges seen in the running conversion
   logic [5:0] rise_cnt_q;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rise_cnt_q <= 6'h00;
      end else if (state_q != sadc_pkg::S_CONV || done_now) begin
         rise_cnt_q <= 6'h00;
      end else if (adc_rise) begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   sequence start_req_s;
      conv_start_wr_i && powered && state_q == sadc_pkg::S_IDLE && !trig_fire;
   endsequence
   sequence conv_begun_s;
      ##[1:260] (state_q == sadc_pkg::S_CONV);
   endsequence

   start_on_edge_a: assert property (start_req_s |-> conv_begun_s)
      else $error("software start did not begin a conversion");
   start_readback_a: assert property (start_req_s |=> conv_start_o)
      else $error("start bit not set after write");
   done_clears_start_a: assert property (done_now && !free_run |=> !conv_start_o)
      else $error("start bit not cleared at completion");
   free_run_keep_a: assert property (done_now && free_run && powered
      |=> conv_start_o && state_q == sadc_pkg::S_CONV && half_q == 6'h00)
      else $error("free running did not restart");
   lock_keeps_result_a: assert property (done_now && lock_q |=> $stable(res_q))
      else $error("locked result bytes changed");
   unlock_update_a: assert property (done_now && !lock_q |=> res_q
      == sadc_pkg::sadc_format($past(core_result_i), $past(left_adjust_i)))
      else $error("result not written after unlock");
   flag_on_drop_a: assert property (done_now |=> conv_done_flag_o)
      else $error("completion flag not set");
   prescale_held_a: assert property (!powered |-> !adc_rise && !adc_fall)
      else $error("prescaler ran while disabled");
   power_gate_a: assert property (!powered |=> !core_ctrl_o.powered
      && state_q == sadc_pkg::S_IDLE)
      else $error("converter active while off");
   normal_len_a: assert property (done_now && kind_q == sadc_pkg::K_NORMAL
      |-> adc_rise && rise_cnt_q == 6'h0c)
      else $error("normal conversion length wrong");
   first_len_a: assert property (done_now && kind_q == sadc_pkg::K_FIRST
      |-> adc_rise && rise_cnt_q == 6'h18)
      else $error("first conversion length wrong");
   auto_len_a: assert property (done_now && kind_q == sadc_pkg::K_AUTO
      |-> adc_fall && rise_cnt_q == 6'h0d)
      else $error("auto conversion length wrong");
   busy_ignore_a: assert property (state_q == sadc_pkg::S_CONV && !done_now && powered
      |=> state_q == sadc_pkg::S_CONV)
      else $error("trigger disturbed running conversion");
   trig_sync_a: assert property (trig_fire |-> $past(trig_lvl, 2) && !$past(trig_lvl, 3))
      else $error("trigger fired without synchronised edge");
   frozen_sel_a: assert property (!track && state_q == sadc_pkg::S_CONV |=> $stable(ch_buf_q))
      else $error("selection changed during conversion");

endmodule // sadc_sequencer

// >>> tb/sadc_core_model.sv
// partner model of the analog core: latches a code on each hold pulse
// assumes core control arrives registered on mclk_i
`timescale 1ns/1ns
module sadc_core_model (
   input wire logic mclk_i,                      // cpu clock
   input wire sadc_pkg::sadc_core_ctrl_s ctrl_i, // control from sequencer
   output logic [9:0] code_o                     // converted code
);
   initial code_o = 10'h155;
   always @(posedge mclk_i) begin
      if (!ctrl_i.powered) begin
         code_o <= ~code_o;
      end else if (ctrl_i.sample_hold) begin
         code_o <= {ctrl_i.channel, ctrl_i.reference, 4'ha};
      end
   end
endmodule // sadc_core_model

// >>> tb/testbench.sv
// testbench: drives control levels and strobes, checks timing and results
// assumes sadc_pkg is compiled first and a divide-by-2 prescaler default
`timescale 1ns/1ns
module testbench;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic conv_enable_i = 1'b0, converter_power_off_i = 1'b1, auto_trigger_enable_i = 1'b0;
   logic [2:0] trigger_source_sel_i = 3'h1, prescale_sel_i = 3'h0;
   logic [3:0] channel_sel_i = 4'h0;
   logic [1:0] reference_sel_i = 2'h0;
   logic left_adjust_i = 1'b0, irq_enable_i = 1'b0;
   logic [4:0] stb = 5'h00;
   logic [7:1] trig_src_i = 7'h00;
   logic [9:0] core_result_i;
   sadc_pkg::sadc_core_ctrl_s core_ctrl_o;
   logic [7:0] result_high_o, result_low_o;
   logic conv_start_o, conv_done_flag_o, irq_o;
   int n_mismatch = 0, cmp_count = 0, n_sh = 0, cyc = 0, t, n;
   localparam int ST = 0, FC = 1, AK = 2, RL = 3, RH = 4;
   localparam logic [3:0] CHS [3] = '{4'he, 4'hf, 4'h5};
   localparam logic [1:0] RFS [3] = '{2'h0, 2'h1, 2'h3};

   sadc_sequencer i_sadc_sequencer (.mclk_i, .arst_n_i, .conv_enable_i,
      .converter_power_off_i, .auto_trigger_enable_i, .trigger_source_sel_i,
      .prescale_sel_i, .channel_sel_i, .reference_sel_i, .left_adjust_i,
      .irq_enable_i, .conv_start_wr_i(stb[ST]), .flag_clear_i(stb[FC]),
      .irq_ack_i(stb[AK]), .read_low_i(stb[RL]), .read_high_i(stb[RH]),
      .trig_src_i, .core_result_i, .core_ctrl_o, .result_high_o,
      .result_low_o, .conv_start_o, .conv_done_flag_o, .irq_o);

   sadc_core_model i_sadc_core_model (.mclk_i, .ctrl_i(core_ctrl_o),
      .code_o(core_result_i));

   always #20 mclk_i = ~mclk_i;

   // cycle count, hold pulse count and hang guard
   always @(posedge mclk_i) begin
      cyc++;
      if (core_ctrl_o.sample_hold === 1'b1) begin
         n_sh++;
      end
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pulse(input int b);
      @(posedge mclk_i) stb[b] <= 1'b1;
      @(posedge mclk_i) stb <= 5'h00;
   endtask

   task automatic wait_flag(output int k);
      k = 0;
      while (conv_done_flag_o !== 1'b1 && k < 400) begin
         @(negedge mclk_i);
         k++;
      end
   endtask

   // clear flag, start, move channel mid-run, check duration window
   task automatic conv(input int lo, input int hi, input logic [3:0] nc);
      int k;
      pulse(FC);
      pulse(ST);
      repeat (3) @(negedge mclk_i);
      check(conv_start_o, 1'b1);
      @(posedge mclk_i) channel_sel_i <= nc;
      wait_flag(k);
      check(k + 4 >= lo && k + 4 <= hi, 1'b1);
      check(conv_start_o, 1'b0);
   endtask

   task automatic res(input logic [3:0] c, input logic [1:0] r, input logic l);
      logic [9:0] code;
      code = {c, r, 4'ha};
      check({result_high_o, result_low_o}, l ? {code, 6'h00} : {6'h00, code});
   endtask

   task automatic wrap_up;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // main sequence of scenarios
   initial begin
      repeat (5) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      check({result_high_o, result_low_o}, 16'h0000);
      check({conv_start_o, conv_done_flag_o, irq_o, core_ctrl_o}, 16'h0000);
      @(posedge mclk_i) conv_enable_i <= 1'b1;
      channel_sel_i <= 4'h3;
      pulse(ST);
      repeat (4) @(negedge mclk_i);
      check({conv_start_o, core_ctrl_o}, 16'h0000);
      check(n_sh, 0);
      @(posedge mclk_i) converter_power_off_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_i) channel_sel_i <= CHS[i];
         reference_sel_i <= RFS[i];
         repeat (3) @(negedge mclk_i);
         check({core_ctrl_o.channel, core_ctrl_o.reference}, {CHS[i], RFS[i]});
      end
      @(posedge mclk_i) irq_enable_i <= 1'b1;
      reference_sel_i <= 2'h1;
      conv(50, 56, 4'h5);
      res(4'h5, 2'h1, 1'b0);
      check(irq_o, 1'b1);
      pulse(FC);
      @(negedge mclk_i);
      check({conv_done_flag_o, irq_o}, 2'b00);
      @(posedge mclk_i) left_adjust_i <= 1'b1;
      channel_sel_i <= 4'h7;
      conv(26, 32, 4'h2);
      res(4'h7, 2'h1, 1'b1);
      pulse(AK);
      @(negedge mclk_i);
      check(conv_done_flag_o, 1'b0);
      pulse(RL);
      conv(26, 32, 4'h2);
      res(4'h7, 2'h1, 1'b1);
      check({conv_done_flag_o, irq_o}, 2'b11);
      pulse(RH);
      conv(26, 32, 4'h2);
      res(4'h2, 2'h1, 1'b1);
      @(posedge mclk_i) prescale_sel_i <= 3'h3;
      conv(104, 118, 4'h2);
      @(posedge mclk_i) prescale_sel_i <= 3'h0;
      auto_trigger_enable_i <= 1'b1;
      pulse(FC);
      t = n_sh;
      @(posedge mclk_i) trig_src_i <= 7'h03;
      repeat (10) @(negedge mclk_i);
      check(conv_start_o, 1'b1);
      @(posedge mclk_i) trig_src_i[1] <= 1'b0;
      @(posedge mclk_i) trig_src_i[1] <= 1'b1;
      wait_flag(n);
      check(n + 12 >= 27 && n + 12 <= 36, 1'b1);
      repeat (80) @(negedge mclk_i);
      check(n_sh - t, 1);
      conv(26, 32, 4'h2);
      @(posedge mclk_i) trig_src_i <= 7'h00;
      trigger_source_sel_i <= 3'h0;
      pulse(FC);
      t = n_sh;
      pulse(ST);
      repeat (200) @(negedge mclk_i);
      check(n_sh - t >= 6, 1'b1);
      check(conv_start_o, 1'b1);
      @(posedge mclk_i) conv_enable_i <= 1'b0;
      repeat (3) @(negedge mclk_i);
      t = n_sh;
      repeat (100) @(negedge mclk_i);
      check({n_sh - t, core_ctrl_o}, 16'h0000);
      wrap_up();
   end
endmodule // testbench
